// >>> hdl/dio_discrete_io.sv
// Discrete contact inputs 9 to 12, twelve relay outputs and their register port.
`timescale 1ns/1ps
module dio_discrete_io
  import dio_pkg::*;
#(
  parameter int                  QUAL_CYC = QUAL_CYCLES,
  parameter logic [CURVE_W-1:0]  HLT_CURVE = 4'h0
) (
  // Clock and reset.
  input  wire logic               i_clock,
  input  wire logic               i_resetn,
  // Contact inputs 9 to 12 and the variant strap, from pins.
  input  wire logic [N_IN-1:0]    i_contact,
  input  wire logic               i_variant_strap,
  // Protection logic state.
  input  wire dio_ind_t           i_ind,
  input  wire dio_keys_t          i_keys,
  input  wire logic [CURVE_W-1:0] i_profile_curve,
  input  wire logic               i_relay_supply,
  // Register port.
  input  wire logic [ADDR_W-1:0]  i_addr,
  input  wire logic [DATA_W-1:0]  i_wdata,
  input  wire logic               i_write,
  input  wire logic               i_read,
  output      logic [DATA_W-1:0]  o_rdata,
  // Relays, commands and interrupt.
  output      logic [N_OUT-1:0]   o_relay,
  output      dio_cmd_t           o_cmd,
  output      logic [CURVE_W-1:0] o_active_curve,
  output      logic               o_nonreclose,
  output      logic               o_clpb,
  output      logic               o_irq
);

  localparam int CNT_W = $clog2(QUAL_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.

  logic              rst_meta;
  logic              rst_n;
  logic [N_IN-1:0]   contact_meta;
  logic [N_IN-1:0]   contact_sync;
  logic              strap_meta;
  logic              strap_sync;

  // Reset is asserted at once and released through two flip-flops.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Contacts and strap are asynchronous to the clock.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      contact_meta <= '0;
      contact_sync <= '0;
      strap_meta   <= 1'b0;
      strap_sync   <= 1'b0;
    end else begin
      contact_meta <= i_contact;
      contact_sync <= contact_meta;
      strap_meta   <= i_variant_strap;
      strap_sync   <= strap_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Variant strap, caught once after reset release.

  logic       universal;
  logic       strap_taken;
  logic [1:0] strap_fill;

  // Counts the edges that the strap synchroniser needs to fill after reset.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_fill <= '0;
    end else begin
      strap_fill <= {strap_fill[0], 1'b1};
    end
  end

  // The strap is sampled once the synchroniser has filled, then held.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      universal   <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken && strap_fill[1]) begin
      universal   <= strap_sync;
      strap_taken <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Contact qualification.

  logic [CNT_W-1:0]  qual_cnt [N_IN];
  logic [N_IN-1:0]   qual;
  logic [N_IN-1:0]   qual_d;
  logic [N_IN-1:0]   rise;

  // A contact changes its qualified state only after holding for the window.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      qual   <= '0;
      qual_d <= '0;
      for (int i = 0; i < N_IN; i++) begin
        qual_cnt[i] <= '0;
      end
    end else begin
      qual_d <= qual;
      for (int i = 0; i < N_IN; i++) begin
        if (contact_sync[i] == qual[i]) begin
          qual_cnt[i] <= '0;
        end else if (qual_cnt[i] == CNT_W'(QUAL_CYC - 1)) begin
          qual_cnt[i] <= '0;
          qual[i]     <= contact_sync[i];
        end else begin
          qual_cnt[i] <= qual_cnt[i] + CNT_W'(1);
        end
      end
    end
  end

  // Each momentary function fires once per qualified rising edge.
  assign rise = qual & ~qual_d;

  ////////////////////////////////////////////////////////////////////////////
  // Supervisory gating and input actions.

  logic supv_disable;
  logic supv_ok;
  logic supv_reject;
  logic nonreclose;
  logic clpb;

  // Supervisory inputs count only when enabled and not blocked.
  assign supv_ok     = !supv_disable && !i_ind.supv_blocked;
  assign supv_reject = (rise[IN_NONRECL] || rise[IN_CLPB]) && !supv_ok;

  // Non-reclosing toggles from the panel key or a valid input 9 pulse.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      nonreclose <= 1'b0;
    end else if (i_keys.nonreclose ^ (rise[IN_NONRECL] && supv_ok)) begin
      nonreclose <= !nonreclose;
    end
  end

  // Cold-load-pickup-blocked toggles from its key or a valid input 10 pulse.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      clpb <= 1'b0;
    end else if (i_keys.clpb ^ (rise[IN_CLPB] && supv_ok)) begin
      clpb <= !clpb;
    end
  end

  // Remote trip commands ignore the supervisory state entirely.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_cmd <= '0;
    end else begin
      o_cmd.trip_reclose    <= rise[IN_TRIP_RECL];
      o_cmd.trip_lockout    <= rise[IN_TRIP_LOCK];
      o_cmd.close_enable    <= !i_ind.hot_line_tag;
      o_cmd.gnd_trip_enable <= !i_ind.gnd_trip_block;
    end
  end

  // Panel state owned here, reported to the protection logic.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_nonreclose <= 1'b0;
      o_clpb       <= 1'b0;
    end else begin
      o_nonreclose <= nonreclose;
      o_clpb       <= clpb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hot line tag curve save and restore.

  logic [CURVE_W-1:0] saved_curve;

  // The profile curve is tracked while untagged and frozen while tagged.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      saved_curve <= '0;
    end else if (!i_ind.hot_line_tag) begin
      saved_curve <= i_profile_curve;
    end
  end

  // Tagged operation uses the tag curve; release returns the saved one.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_active_curve <= '0;
    end else if (i_ind.hot_line_tag) begin
      o_active_curve <= HLT_CURVE;
    end else begin
      o_active_curve <= saved_curve;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Relay outputs.

  logic [N_OUT-1:0] relay_want;
  logic             alt_any;

  // Profile 3 does not exist as such on the universal variant.
  assign alt_any = i_ind.alt_profile[0] || i_ind.alt_profile[1] ||
                   (i_ind.alt_profile[2] && !universal);

  // Indicator state mapped to relay positions.
  always_comb begin
    relay_want                = '0;
    relay_want[OUT_NORMAL]    = !alt_any;
    relay_want[OUT_NONRECL]   = nonreclose;
    relay_want[OUT_CLPB]      = clpb;
    relay_want[OUT_SUPV_BLK]  = i_ind.supv_blocked;
    relay_want[OUT_AC_POWER]  = i_ind.ac_power;
    relay_want[OUT_CTRL_OK]   = i_ind.control_ok;
    relay_want[OUT_RECL_OPEN] = i_ind.recloser_open;
    relay_want[OUT_HLT]       = i_ind.hot_line_tag;
    relay_want[OUT_GND_BLK]   = i_ind.gnd_trip_block;
    relay_want[OUT_ALT1]      = i_ind.alt_profile[0];
    relay_want[OUT_ALT2]      = i_ind.alt_profile[1];
    if (universal) begin
      relay_want[OUT_ALT3]    = i_ind.switch_mode;
    end else begin
      relay_want[OUT_ALT3]    = i_ind.alt_profile[2];
    end
  end

  // Without relay supply the non-latched relays drop and latched ones hold.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_relay <= '0;
    end else if (i_relay_supply) begin
      o_relay <= relay_want;
    end else begin
      o_relay[N_NONLATCH-1:0] <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status, mask and interrupt.

  logic [N_EV-1:0] status;
  logic [N_EV-1:0] mask;
  logic [N_EV-1:0] events;
  logic            rd_status;

  assign events    = {supv_reject, rise};
  assign rd_status = i_read && (i_addr == REG_STATUS);

  // A read clears the status, but an event in the same cycle still sets it.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else if (rd_status) begin
      status <= events;
    end else begin
      status <= status | events;
    end
  end

  // Interrupt is high while any unmasked status bit is set.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port.

  // Writable registers.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      mask         <= MASK_RESET;
      supv_disable <= CTRL_RESET;
    end else if (i_write) begin
      if (i_addr == REG_MASK) begin
        mask <= i_wdata[N_EV-1:0];
      end else if (i_addr == REG_CTRL) begin
        supv_disable <= i_wdata[CTRL_SUPV_DIS];
      end
    end
  end

  // Read data stands in the cycle after the read strobe; unmapped reads zero.
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= '0;
    end else if (!i_read) begin
      o_rdata <= '0;
    end else if (i_addr == REG_STATUS) begin
      o_rdata <= DATA_W'(status);
    end else if (i_addr == REG_MASK) begin
      o_rdata <= DATA_W'(mask);
    end else if (i_addr == REG_CTRL) begin
      o_rdata <= DATA_W'(supv_disable);
    end else if (i_addr == REG_INPUT) begin
      o_rdata <= DATA_W'(qual);
    end else if (i_addr == REG_RELAY) begin
      o_rdata <= DATA_W'(o_relay);
    end else if (i_addr == REG_STATE) begin
      o_rdata <= DATA_W'({universal, supv_ok, clpb, nonreclose});
    end else begin
      o_rdata <= '0;
    end
  end

endmodule

// >>> pkg/dio_pkg.sv
// Constants, register map and carrier types of the discrete input/output block.
package dio_pkg;

  // Clock rate and contact qualification window.
  localparam int CLOCK_HZ     = 50_000_000;
  localparam int QUAL_TIME_US = 10_000;
  localparam int QUAL_CYCLES  = QUAL_TIME_US * (CLOCK_HZ / 1_000_000);
  // Length of a momentary contact pulse from the remote station.
  localparam int MOMENTARY_MS = 250;

  // Widths.
  localparam int N_IN    = 4;
  localparam int N_OUT   = 12;
  localparam int N_EV    = 5;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int CURVE_W = 4;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MASK   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_INPUT  = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_RELAY  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATE  = 8'h14;

  // Contact input positions (contact inputs 9 to 12) and event bits.
  localparam int IN_NONRECL   = 0;
  localparam int IN_CLPB      = 1;
  localparam int IN_TRIP_RECL = 2;
  localparam int IN_TRIP_LOCK = 3;
  localparam int EV_REJECT    = 4;

  // Control register fields and reset values.
  localparam int CTRL_SUPV_DIS = 0;
  localparam logic [N_EV-1:0] MASK_RESET = 5'h00;
  localparam logic            CTRL_RESET = 1'b0;

  // Relay output positions (output n sits at bit n-1).
  localparam int OUT_NORMAL    = 0;
  localparam int OUT_NONRECL   = 1;
  localparam int OUT_CLPB      = 2;
  localparam int OUT_SUPV_BLK  = 3;
  localparam int OUT_AC_POWER  = 4;
  localparam int OUT_CTRL_OK   = 5;
  localparam int OUT_RECL_OPEN = 6;
  localparam int OUT_HLT       = 7;
  localparam int OUT_GND_BLK   = 8;
  localparam int OUT_ALT1      = 9;
  localparam int OUT_ALT2      = 10;
  localparam int OUT_ALT3      = 11;
  localparam int N_NONLATCH    = 6;

  // Panel indicator states from the protection logic.
  typedef struct packed {
    logic       ac_power;
    logic       control_ok;
    logic       recloser_open;
    logic       hot_line_tag;
    logic       gnd_trip_block;
    logic       supv_blocked;
    logic [2:0] alt_profile;
    logic       switch_mode;
  } dio_ind_t;

  // One-cycle panel key presses.
  typedef struct packed {
    logic nonreclose;
    logic clpb;
  } dio_keys_t;

  // Commands to the protection logic.
  typedef struct packed {
    logic trip_reclose;
    logic trip_lockout;
    logic close_enable;
    logic gnd_trip_enable;
  } dio_cmd_t;

endpackage

// >>> verif/dio_remote_station.sv
// Remote station model that closes contact inputs 9 to 12 for a set time.
`timescale 1ns/1ps
module dio_remote_station (
  // Clock, reset and commands.
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  input  wire logic [3:0] i_fire,
  input  wire logic [7:0] i_len,
  // Contact pins.
  output      logic [3:0] o_contact
);
  logic [7:0] left [4];

  // A fired contact stays closed for i_len cycles, then opens again.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    for (int k = 0; k < 4; k++) begin
      if (!i_resetn) begin
        left[k] <= 8'h00;
      end else if (i_fire[k]) begin
        left[k] <= i_len;
      end else if (left[k] != 8'h00) begin
        left[k] <= left[k] - 8'h01;
      end
    end
  end

  // The closure is a clean level for the whole pulse.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_contact[k] = (left[k] != 8'h00);
    end
  end
endmodule

// >>> verif/dio_discrete_io_properties.sv
// Concurrent checks on the ports of the discrete input/output block.
`timescale 1ns/1ps
module dio_discrete_io_properties
  import dio_pkg::*;
(
  // Watched ports.
  input wire logic              i_clock,
  input wire logic              i_resetn,
  input wire logic [N_IN-1:0]   i_contact,
  input wire logic              i_variant_strap,
  input wire dio_ind_t          i_ind,
  input wire dio_keys_t         i_keys,
  input wire logic              i_relay_supply,
  input wire logic              i_read,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic [N_OUT-1:0]  o_relay,
  input wire dio_cmd_t          o_cmd,
  input wire logic              o_nonreclose,
  input wire logic              o_clpb
);
  logic [5:0] up;
  logic       ok;

  // Checks start only once the synchronised reset has fully run out.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      up <= 6'h00;
    end else begin
      up <= {up[4:0], 1'b1};
    end
  end
  // The variant strap is caught a few edges after release, so wait for it.
  assign ok = up[5];

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!ok);

  // A lockout command lasts one cycle and is not repeated at once.
  sequence s_one_pulse;
    o_cmd.trip_lockout ##1 !o_cmd.trip_lockout [*3];
  endsequence

  AST_NORMAL_OUT: assert property (i_relay_supply |=> o_relay[0] ==
    ($past(i_ind.alt_profile[1:0]) == 2'h0 && ($past(i_variant_strap)
    || !$past(i_ind.alt_profile[2])))) else $error("normal profile relay wrong");
  AST_TOGGLE_OUT: assert property (i_relay_supply |=>
    o_relay[2:1] == {o_clpb, o_nonreclose}) else $error("toggle relays wrong");
  AST_NONLATCH: assert property (i_relay_supply |=> o_relay[5:3] ==
    $past({i_ind.control_ok, i_ind.ac_power, i_ind.supv_blocked}))
    else $error("non-latched relays wrong");
  AST_LATCHED: assert property (i_relay_supply |=> o_relay[10:6] ==
    $past({i_ind.alt_profile[1:0], i_ind.gnd_trip_block, i_ind.hot_line_tag,
    i_ind.recloser_open})) else $error("latched relays wrong");
  AST_OUT12: assert property (i_relay_supply |=> o_relay[11] ==
    ($past(i_variant_strap) ? $past(i_ind.switch_mode) : $past(i_ind.alt_profile[2])))
    else $error("relay 12 wrong");
  AST_SUPPLY_LOSS: assert property (!i_relay_supply |=> o_relay[5:0] == 6'h00
    && $stable(o_relay[11:6])) else $error("relay supply loss wrong");
  AST_INHIBIT: assert property (o_cmd.close_enable == !$past(i_ind.hot_line_tag)
    && o_cmd.gnd_trip_enable == !$past(i_ind.gnd_trip_block))
    else $error("close or ground enable wrong");
  AST_LOCK_PULSE: assert property ($rose(o_cmd.trip_lockout) |-> s_one_pulse
    and $past(i_contact[3], 2) and $past(i_contact[3], 5)) else $error("lockout pulse");
  AST_RECL_CAUSE: assert property (o_cmd.trip_reclose |->
    $past(i_contact[2], 2) && $past(i_contact[2], 5)) else $error("reclose pulse");
  AST_TOGGLE_CAUSE: assert property ($changed(o_nonreclose) |->
    $past(i_keys.nonreclose, 2) || $past(i_contact[0], 3)) else $error("stray toggle");
  AST_RDATA_IDLE: assert property (!$past(i_read) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule

bind dio_discrete_io dio_discrete_io_properties u_chk (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_contact(i_contact),
  .i_variant_strap(i_variant_strap), .i_ind(i_ind), .i_keys(i_keys),
  .i_relay_supply(i_relay_supply), .i_read(i_read), .o_rdata(o_rdata),
  .o_relay(o_relay), .o_cmd(o_cmd), .o_nonreclose(o_nonreclose), .o_clpb(o_clpb)
);

// >>> verif/testbench.sv
// Self-checking bench for the discrete input/output block.
`timescale 1ns/1ps
module testbench;
  import dio_pkg::*;
  logic               i_clock = 1'b0;
  logic               i_resetn = 1'b0;
  logic               i_variant_strap = 1'b0;
  dio_ind_t           i_ind = '0;
  dio_keys_t          i_keys = '0;
  logic [CURVE_W-1:0] i_profile_curve = 4'h0;
  logic               i_relay_supply = 1'b1;
  logic [ADDR_W-1:0]  i_addr = 8'h00;
  logic [DATA_W-1:0]  i_wdata = 32'h0;
  logic               i_write = 1'b0;
  logic               i_read = 1'b0;
  logic [3:0]         fire = 4'h0;
  logic [7:0]         len = 8'h08;
  logic [N_IN-1:0]    i_contact;
  logic [DATA_W-1:0]  o_rdata;
  logic [N_OUT-1:0]   o_relay;
  dio_cmd_t           o_cmd;
  logic [CURVE_W-1:0] o_active_curve;
  logic               o_nonreclose;
  logic               o_clpb;
  logic               o_irq;
  logic               nr = 1'b0;
  logic               cl = 1'b0;
  int                 failures = 0;
  int                 checks = 0;
  int                 cycles = 0;
  int                 n_rl = 0;
  int                 n_lk = 0;

  dio_discrete_io #(.QUAL_CYC(4)) dut (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_contact(i_contact), .i_variant_strap(i_variant_strap), .i_ind(i_ind),
    .i_keys(i_keys), .i_profile_curve(i_profile_curve), .i_relay_supply(i_relay_supply),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
    .o_rdata(o_rdata), .o_relay(o_relay), .o_cmd(o_cmd), .o_active_curve(o_active_curve),
    .o_nonreclose(o_nonreclose), .o_clpb(o_clpb), .o_irq(o_irq));
  dio_remote_station far (.i_clock(i_clock), .i_resetn(i_resetn), .i_fire(fire),
    .i_len(len), .o_contact(i_contact));

  // Clock, command pulse counters and the hang limit.
  always #10 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles++;
    if (o_cmd.trip_reclose === 1'b1) n_rl++;
    if (o_cmd.trip_lockout === 1'b1) n_lk++;
    if (cycles == 20000) begin
      failures++;
      $display("[FAIL] %0t run did not finish", $time);
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 cmp(o_rdata, exp);
  endtask
  task automatic pulse(input logic [3:0] ch, input logic [7:0] n);
    @(posedge i_clock);
    fire <= ch;
    len <= n;
    @(posedge i_clock);
    fire <= 4'h0;
    idle(26);
  endtask
  task automatic rst(input logic strap);
    i_resetn <= 1'b0;
    i_variant_strap <= strap;
    idle(10);
    i_resetn <= 1'b1;
    nr = 1'b0;
    cl = 1'b0;
    idle(4);
  endtask
  function automatic logic [11:0] er(input dio_ind_t d, input logic u);
    er = {u ? d.switch_mode : d.alt_profile[2], d.alt_profile[1:0], d.gnd_trip_block,
      d.hot_line_tag, d.recloser_open, d.control_ok, d.ac_power, d.supv_blocked, cl, nr,
      d.alt_profile[1:0] == 2'h0 && (u || !d.alt_profile[2])};
  endfunction

  // Main sequence of tests.
  initial begin
    rst(1'b0);
    rd(REG_MASK, 32'h0); rd(REG_CTRL, 32'h0); rd(REG_STATE, 32'h4); rd(8'h20, 32'h0);
    rd(REG_STATUS, 32'h0);
    $display("test reset_values done");
    wr(REG_MASK, 32'h1f);
    pulse(4'h1, 8'h08); nr = 1'b1;
    cmp(o_nonreclose, nr);
    cmp(o_irq, 1'b1);
    rd(REG_STATUS, 32'h1);
    idle(2);
    cmp(o_irq, 1'b0);
    pulse(4'h2, 8'h08); cl = 1'b1;
    cmp(o_clpb, cl);
    pulse(4'h1, 8'h02);
    cmp(o_nonreclose, nr);
    rd(REG_STATUS, 32'h2);
    i_keys <= 2'b10;
    @(posedge i_clock) i_keys <= 2'b00;
    nr = 1'b0;
    idle(3);
    cmp(o_relay, er(i_ind, 1'b0));
    $display("test supervisory_accepted done");
    wr(REG_CTRL, 32'h1);
    pulse(4'h1, 8'h08);
    cmp(o_nonreclose, nr);
    rd(REG_STATUS, 32'h11);
    wr(REG_CTRL, 32'h0); wr(REG_MASK, 32'h0d);
    i_ind.supv_blocked <= 1'b1;
    pulse(4'h2, 8'h08);
    cmp(o_clpb, cl);
    cmp(o_irq, 1'b0);
    pulse(4'h8, 8'h08);
    cmp(n_lk, 1);
    wr(REG_CTRL, 32'h1);
    pulse(4'h4, 8'h08);
    cmp(n_rl, 1);
    cmp(o_irq, 1'b1);
    rd(REG_STATUS, 32'h1e);
    wr(REG_CTRL, 32'h0);
    $display("test supervisory_refused done");
    for (int i = 0; i < 11; i++) begin
      i_ind <= (i == 10) ? 10'h3ff : 10'h001 << i;
      idle(3);
      cmp(o_relay, er(i_ind, 1'b0));
    end
    i_relay_supply <= 1'b0;
    i_ind <= '0;
    idle(3);
    cmp(o_relay, 32'hfc0);
    i_relay_supply <= 1'b1;
    i_profile_curve <= 4'h5;
    i_ind.gnd_trip_block <= 1'b1;
    idle(3);
    i_ind.hot_line_tag <= 1'b1;
    idle(3);
    cmp({o_cmd.close_enable, o_cmd.gnd_trip_enable, o_active_curve}, 6'h00);
    i_ind <= '0;
    idle(3);
    cmp({o_cmd.close_enable, o_cmd.gnd_trip_enable, o_active_curve}, 6'h35);
    $display("test relays done");
    rst(1'b1);
    rd(REG_STATE, 32'hc);
    i_ind <= 10'h009;
    idle(3);
    cmp(o_relay, er(i_ind, 1'b1));
    $display("test universal done");
    conclude();
  end
endmodule
